/* logic/pfds_pkg.sv */
// package: register map, field layout and reset values of the pin function and drive selector
// What this block does
// - drive field 00 weakest, 11 strongest, 01 and 10 rising in between
// - first drive register: bits 7:6 port b 7-4, 5:4 b 3-0, 3:2 a 7-4, 1:0 a 3-0
// - second drive register: 7:6 port d 6-4, 5:4 d 3-0, 3:2 c 7-4, 1:0 c 3-0
// - third drive register: 7:6 port f 7-4, 5:4 f 3-0, 3:2 e pin 4, 1:0 e 3-0
// - per-port output function registers; peripheral input pins follow the function codes and direction bits
// - port a pin 3: codes 00-10 gpio with interrupt 1, 11 serial data output
// - port a pin 1: codes 00-10 gpio with interrupt 0, 11 serial slave select
// - port a low function bits 5:4 and 1:0 unimplemented, read zero
// - port a pin 7: codes 00-10 gpio with interrupt 1, 11 uart 0 transmit
// - port a pin 6: 00-10 gpio with interrupt 0, 11 uart 0 receive/transmit
// - port a pin 5: 00-10 gpio with interrupt 3, 11 serial clock
// - port a pin 4: 00-10 gpio with interrupt 2, 11 serial data input line
// - port b pin 3: 00/01 gpio, 10 timer 2 pulse, 11 analog 14
// - port b pin 2: 00 gpio timer2 clock, 01 uart2, 10 timer3 pulse, 11 analog 13
// - port b pin 1: 00/01 gpio timer3 clock, 10 uart2 transmit, 11 analog 12
// - port b pin 0: 00-10 gpio standard timer 2 clock, 11 comparator 0 output
// - direction bit 1 input, 0 push-pull output, resets to 1
package pfds_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_DRIVE_AB   = 8'h00;
  localparam logic [7:0] ADDR_DRIVE_CD   = 8'h04;
  localparam logic [7:0] ADDR_DRIVE_EF   = 8'h08;
  localparam logic [7:0] ADDR_FUNC_A_LOW = 8'h0C;
  localparam logic [7:0] ADDR_FUNC_A_HI  = 8'h10;
  localparam logic [7:0] ADDR_FUNC_B_LOW = 8'h14;
  localparam logic [7:0] ADDR_DIR_A      = 8'h18;
  localparam logic [7:0] ADDR_DIR_B      = 8'h1C;
  localparam logic [7:0] ADDR_STATUS     = 8'h20;
  // readable bits of the port a low function register
  localparam logic [7:0] FUNC_A_LOW_MASK = 8'hCC;
  localparam logic [7:0] FIELD_RESET     = 8'h00;
  localparam logic [7:0] DIR_RESET       = 8'hFF;
  // two-bit function codes
  localparam logic [1:0] CODE_00 = 2'h0;
  localparam logic [1:0] CODE_01 = 2'h1;
  localparam logic [1:0] CODE_10 = 2'h2;
  localparam logic [1:0] CODE_11 = 2'h3;
  // inactive (idle) level of a peripheral input
  localparam logic INPUT_IDLE = 1'b1;

  typedef struct packed {
    logic [7:0] drive_ab;
    logic [7:0] drive_cd;
    logic [7:0] drive_ef;
    logic [7:0] func_a_low;
    logic [7:0] func_a_hi;
    logic [7:0] func_b_low;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
  } pfds_regs_t;

  // peripheral outputs that may reach ports a and b
  typedef struct packed {
    logic serial_data_output;
    logic serial_slave_select;
    logic serial_clock;
    logic serial_data_input_line;
    logic uart0_transmit;
    logic uart2_transmit;
    logic timer2_pulse_output;
    logic timer3_pulse_output;
    logic comparator0_output;
  } pfds_periph_out_t;

  // peripheral inputs fed from ports a and b
  typedef struct packed {
    logic [3:0] external_interrupt_input;
    logic       uart0_receive;
    logic       uart2_receive;
    logic       serial_clock_in;
    logic       serial_data_in;
    logic       serial_slave_select_in;
    logic       timer2_clock_input;
    logic       timer3_clock_input;
    logic       standard_timer2_clock_input;
  } pfds_periph_in_t;

  // per-pin driver control
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] analog_en;
    logic [31:0] drive_level;
  } pfds_pins_t;

  typedef struct packed {
    pfds_regs_t      regs;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    pfds_pins_t      pins;
    pfds_periph_in_t pin_in;
    logic [7:0]      drive_cd;
    logic [7:0]      drive_ef;
  } pfds_state_t;
endpackage

/* logic/pfds_top.sv */
// pin function and drive selector for ports a and b with an apb register slave
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module pfds_top (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // gpio data and pins of ports a (bits 7:0) and b (bits 15:8)
  input  wire logic [15:0]                gpio_out,
  input  wire logic [15:0]                pin_in,
  output logic      [15:0]                pin_out,
  output logic      [15:0]                pin_oe,
  output logic      [15:0]                analog_en,
  output logic      [31:0]                drive_level,
  output logic      [7:0]                 drive_level_ports_c_d,
  output logic      [7:0]                 drive_level_ports_e_f,
  // peripherals
  input  wire pfds_pkg::pfds_periph_out_t periph_out,
  output pfds_pkg::pfds_periph_in_t       periph_in
);
  pfds_pkg::pfds_state_t s_q;
  pfds_pkg::pfds_state_t s_d;
  logic                  access;
  logic [1:0]            fsel [16];
  logic [15:0]           gp;
  logic [15:0]           po;
  logic [15:0]           pe;

  assign access = psel && penable && !s_q.pready;

  // --------------------------------------------------------------
  // function field of each pin
  // --------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      fsel[i] = pfds_pkg::CODE_00;
    end
    fsel[3]  = s_q.regs.func_a_low[7:6];
    fsel[1]  = s_q.regs.func_a_low[3:2];
    fsel[7]  = s_q.regs.func_a_hi[7:6];
    fsel[6]  = s_q.regs.func_a_hi[5:4];
    fsel[5]  = s_q.regs.func_a_hi[3:2];
    fsel[4]  = s_q.regs.func_a_hi[1:0];
    fsel[11] = s_q.regs.func_b_low[7:6];
    fsel[10] = s_q.regs.func_b_low[5:4];
    fsel[9]  = s_q.regs.func_b_low[3:2];
    fsel[8]  = s_q.regs.func_b_low[1:0];
  end

  // --------------------------------------------------------------
  // pin roles: gpio, peripheral output or analog channel
  // --------------------------------------------------------------
  // gp high leaves the pin under its direction bit; a peripheral drives whatever the direction
  always_comb begin
    gp = 16'hFFFF;
    po = 16'h0000;
    pe = 16'h0000;
    if (fsel[3] == pfds_pkg::CODE_11) begin
      gp[3] = 1'b0;
      po[3] = periph_out.serial_data_output;
    end
    if (fsel[1] == pfds_pkg::CODE_11) begin
      gp[1] = 1'b0;
      po[1] = periph_out.serial_slave_select;
    end
    if (fsel[7] == pfds_pkg::CODE_11) begin
      gp[7] = 1'b0;
      po[7] = periph_out.uart0_transmit;
    end
    // single-wire use: the pin transmits and reads itself back as receive
    if (fsel[6] == pfds_pkg::CODE_11) begin
      gp[6] = 1'b0;
      po[6] = periph_out.uart0_transmit;
    end
    if (fsel[5] == pfds_pkg::CODE_11) begin
      gp[5] = 1'b0;
      po[5] = periph_out.serial_clock;
    end
    if (fsel[4] == pfds_pkg::CODE_11) begin
      gp[4] = 1'b0;
      po[4] = periph_out.serial_data_input_line;
    end
    if (fsel[11] == pfds_pkg::CODE_10) begin
      gp[11] = 1'b0;
      po[11] = periph_out.timer2_pulse_output;
    end
    if (fsel[11] == pfds_pkg::CODE_11) begin
      gp[11] = 1'b0;
      pe[11] = 1'b1;
    end
    if (fsel[10] == pfds_pkg::CODE_01) begin
      gp[10] = 1'b0;
      po[10] = periph_out.uart2_transmit;
    end
    if (fsel[10] == pfds_pkg::CODE_10) begin
      gp[10] = 1'b0;
      po[10] = periph_out.timer3_pulse_output;
    end
    if (fsel[10] == pfds_pkg::CODE_11) begin
      gp[10] = 1'b0;
      pe[10] = 1'b1;
    end
    if (fsel[9] == pfds_pkg::CODE_10) begin
      gp[9] = 1'b0;
      po[9] = periph_out.uart2_transmit;
    end
    if (fsel[9] == pfds_pkg::CODE_11) begin
      gp[9] = 1'b0;
      pe[9] = 1'b1;
    end
    if (fsel[8] == pfds_pkg::CODE_11) begin
      gp[8] = 1'b0;
      po[8] = periph_out.comparator0_output;
    end
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    rd = 32'h0000_0000;
    s_d = s_q;
    s_d.pready  = access;
    s_d.pslverr = 1'b0;
    if (access) begin
      unique case (paddr)
        pfds_pkg::ADDR_DRIVE_AB:   rd = {24'h000000, s_q.regs.drive_ab};
        pfds_pkg::ADDR_DRIVE_CD:   rd = {24'h000000, s_q.regs.drive_cd};
        pfds_pkg::ADDR_DRIVE_EF:   rd = {24'h000000, s_q.regs.drive_ef};
        pfds_pkg::ADDR_FUNC_A_LOW: rd = {24'h000000, s_q.regs.func_a_low};
        pfds_pkg::ADDR_FUNC_A_HI:  rd = {24'h000000, s_q.regs.func_a_hi};
        pfds_pkg::ADDR_FUNC_B_LOW: rd = {24'h000000, s_q.regs.func_b_low};
        pfds_pkg::ADDR_DIR_A:      rd = {24'h000000, s_q.regs.dir_a};
        pfds_pkg::ADDR_DIR_B:      rd = {24'h000000, s_q.regs.dir_b};
        pfds_pkg::ADDR_STATUS:     rd = {16'h0000, pin_in};
        default:                   s_d.pslverr = 1'b1;
      endcase
      if (pwrite) begin
        unique case (paddr)
          pfds_pkg::ADDR_DRIVE_AB:   s_d.regs.drive_ab = pwdata[7:0];
          pfds_pkg::ADDR_DRIVE_CD:   s_d.regs.drive_cd = pwdata[7:0];
          pfds_pkg::ADDR_DRIVE_EF:   s_d.regs.drive_ef = pwdata[7:0];
          pfds_pkg::ADDR_FUNC_A_LOW: s_d.regs.func_a_low = pwdata[7:0] & pfds_pkg::FUNC_A_LOW_MASK;
          pfds_pkg::ADDR_FUNC_A_HI:  s_d.regs.func_a_hi = pwdata[7:0];
          pfds_pkg::ADDR_FUNC_B_LOW: s_d.regs.func_b_low = pwdata[7:0];
          pfds_pkg::ADDR_DIR_A:      s_d.regs.dir_a = pwdata[7:0];
          pfds_pkg::ADDR_DIR_B:      s_d.regs.dir_b = pwdata[7:0];
          default:                   s_d.pslverr = 1'b1;
        endcase
        rd = 32'h0000_0000;
      end
    end
    s_d.prdata = rd;

    // pin drivers; gpio pins follow the direction bit, peripherals drive actively
    for (int i = 0; i < 16; i++) begin
      logic dir;
      dir = (i < 8) ? s_q.regs.dir_a[i[2:0]] : s_q.regs.dir_b[i[2:0]];
      s_d.pins.analog_en[i] = pe[i];
      s_d.pins.out[i] = gp[i] ? gpio_out[i] : po[i];
      s_d.pins.oe[i]  = gp[i] ? !dir : !pe[i];
    end

    // four pins share each field of the first drive register
    s_d.pins.drive_level = {{4{s_q.regs.drive_ab[7:6]}}, {4{s_q.regs.drive_ab[5:4]}},
                            {4{s_q.regs.drive_ab[3:2]}}, {4{s_q.regs.drive_ab[1:0]}}};
    s_d.drive_cd = s_q.regs.drive_cd;
    s_d.drive_ef = s_q.regs.drive_ef;

    // peripheral inputs: taken from the first listed pin that carries them as input, else idle level
    s_d.pin_in.external_interrupt_input = {4{pfds_pkg::INPUT_IDLE}};
    s_d.pin_in.external_interrupt_input[1] =
      (fsel[3] != pfds_pkg::CODE_11 && s_q.regs.dir_a[3]) ? pin_in[3] :
      (fsel[7] != pfds_pkg::CODE_11 && s_q.regs.dir_a[7]) ? pin_in[7] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.external_interrupt_input[0] =
      (fsel[1] != pfds_pkg::CODE_11 && s_q.regs.dir_a[1]) ? pin_in[1] :
      (fsel[6] != pfds_pkg::CODE_11 && s_q.regs.dir_a[6]) ? pin_in[6] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.external_interrupt_input[3] =
      (fsel[5] != pfds_pkg::CODE_11 && s_q.regs.dir_a[5]) ? pin_in[5] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.external_interrupt_input[2] =
      (fsel[4] != pfds_pkg::CODE_11 && s_q.regs.dir_a[4]) ? pin_in[4] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.uart0_receive = (fsel[6] == pfds_pkg::CODE_11) ? pin_in[6] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.serial_clock_in = (fsel[5] == pfds_pkg::CODE_11) ? pin_in[5] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.serial_data_in = (fsel[4] == pfds_pkg::CODE_11) ? pin_in[4] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.serial_slave_select_in = (fsel[1] == pfds_pkg::CODE_11) ? pin_in[1] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.uart2_receive = (fsel[10] == pfds_pkg::CODE_01) ? pin_in[10] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.timer2_clock_input =
      (fsel[10] == pfds_pkg::CODE_00 && s_q.regs.dir_b[2]) ? pin_in[10] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.timer3_clock_input =
      (fsel[9][1] == 1'b0 && s_q.regs.dir_b[1]) ? pin_in[9] : pfds_pkg::INPUT_IDLE;
    s_d.pin_in.standard_timer2_clock_input =
      (fsel[8] != pfds_pkg::CODE_11 && s_q.regs.dir_b[0]) ? pin_in[8] : pfds_pkg::INPUT_IDLE;

    if (!rst_n) begin
      s_d = '0;
      s_d.regs.dir_a = pfds_pkg::DIR_RESET;
      s_d.regs.dir_b = pfds_pkg::DIR_RESET;
      s_d.regs.drive_ab = pfds_pkg::FIELD_RESET;
      s_d.pin_in = '1;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign prdata                = s_q.prdata;
  assign pready                = s_q.pready;
  assign pslverr               = s_q.pslverr;
  assign pin_out               = s_q.pins.out;
  assign pin_oe                = s_q.pins.oe;
  assign analog_en             = s_q.pins.analog_en;
  assign drive_level           = s_q.pins.drive_level;
  assign drive_level_ports_c_d = s_q.drive_cd;
  assign drive_level_ports_e_f = s_q.drive_ef;
  assign periph_in             = s_q.pin_in;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  reserved_zero_a: assert property (s_q.regs.func_a_low[5:4] == 2'h0 && s_q.regs.func_a_low[1:0] == 2'h0)
    else $error("port a low reserved bits not zero");
  drive_map_a: assert property (drive_level[31:30] == $past(s_q.regs.drive_ab[7:6]) &&
                                drive_level[1:0] == $past(s_q.regs.drive_ab[1:0]))
    else $error("drive level does not follow register");
  sdo_route_a: assert property (fsel[3] == 2'h3 |=> pin_oe[3] && pin_out[3] == $past(periph_out.serial_data_output))
    else $error("serial data output not routed");
  gpio_dir_a: assert property (fsel[3] != 2'h3 |=> pin_oe[3] == !$past(s_q.regs.dir_a[3]))
    else $error("gpio direction wrong");
  analog_a: assert property (fsel[11] == 2'h3 |=> analog_en[11] && !pin_oe[11])
    else $error("analog channel 14 not connected");
  idle_int_a: assert property (fsel[5] == 2'h3 |=> periph_in.external_interrupt_input[3])
    else $error("interrupt 3 not idle");
  uart2_a: assert property (fsel[9] == 2'h2 |=> pin_out[9] == $past(periph_out.uart2_transmit))
    else $error("uart 2 transmit not routed");
  comp_a: assert property (fsel[8] == 2'h3 |=> pin_out[8] == $past(periph_out.comparator0_output))
    else $error("comparator output not routed");
  reset_a: assert property (disable iff (1'b0) !rst_n ##1 rst_n |-> s_q.regs.dir_a == 8'hFF && s_q.regs.func_a_hi == 8'h00)
    else $error("reset values wrong");
  apb_ans_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  scs_route_a: assert property (fsel[1] == 2'h3 |=> pin_oe[1] && pin_out[1] == $past(periph_out.serial_slave_select))
    else $error("slave select not routed");
  uart0_tx_a: assert property (fsel[7] == 2'h3 |=> pin_out[7] == $past(periph_out.uart0_transmit))
    else $error("uart 0 transmit not routed");
  uart0_rx_a: assert property (fsel[6] == 2'h3 |=> periph_in.uart0_receive == $past(pin_in[6]))
    else $error("uart 0 receive not routed");
  sclk_route_a: assert property (fsel[5] == 2'h3 |=> pin_out[5] == $past(periph_out.serial_clock))
    else $error("serial clock not routed");
  sdi_route_a: assert property (fsel[4] == 2'h3 |=> pin_out[4] == $past(periph_out.serial_data_input_line))
    else $error("serial data line not routed");
  tp2_route_a: assert property (fsel[11] == 2'h2 |=> pin_out[11] == $past(periph_out.timer2_pulse_output))
    else $error("timer 2 pulse not routed");
  tp3_route_a: assert property (fsel[10] == 2'h2 |=> pin_out[10] == $past(periph_out.timer3_pulse_output))
    else $error("timer 3 pulse not routed");
  uart2_rx_a: assert property (fsel[10] == 2'h1 |=> periph_in.uart2_receive == $past(pin_in[10]))
    else $error("uart 2 receive not routed");
  analog12_a: assert property (fsel[9] == 2'h3 |=> analog_en[9] && !pin_oe[9])
    else $error("analog channel 12 not connected");
  drive_copy_a: assert property (drive_level_ports_c_d == $past(s_q.regs.drive_cd) &&
                                 drive_level_ports_e_f == $past(s_q.regs.drive_ef))
    else $error("drive copies do not follow registers");
  tclk_idle_a: assert property (!s_q.regs.dir_b[1] |=> periph_in.timer3_clock_input)
    else $error("timer 3 clock not idle");
  stclk_idle_a: assert property (fsel[8] == 2'h3 |=> periph_in.standard_timer2_clock_input)
    else $error("standard timer 2 clock not idle");

  write_c: cover property (psel && penable && pwrite && pready);
  uart0_c: cover property (fsel[7] == 2'h3);
  analog_c: cover property (analog_en[10]);
  slverr_c: cover property (pslverr && pready);
  gpio_in_c: cover property (!periph_in.timer2_clock_input);
endmodule

/* bench/pfds_pin_model.sv */
// model of the package pins and the board around ports a and b
`timescale 1ns/1ps
module pfds_pin_model (
  // from the selector
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  // level the board puts on an undriven pin
  input  wire logic [15:0] ext_level,
  // back into the selector
  output logic      [15:0] pin_in
);
  // --------------------------------------------------------------
  // pin levels
  // --------------------------------------------------------------
  // a driven pin reads back its own level, so the status read shows the wire
  always_comb begin
    for (int n = 0; n < 16; n++) begin
      pin_in[n] = pin_oe[n] ? pin_out[n] : ext_level[n];
    end
  end
endmodule

/* bench/pin_function_and_drive_select_test.sv */
// self-checking bench of the pin function and drive selector
`timescale 1ns/1ps
`define chk(name, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", name, (exp), (got)); end end
module pin_function_and_drive_select_test;
  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic [7:0]                 paddr = 8'h00;
  logic [31:0]                pwdata = 32'h0;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [15:0]                gpio_out = 16'h0;
  logic [15:0]                ext_level = 16'hFFFF;
  logic [15:0]                pin_in;
  logic [15:0]                pin_out;
  logic [15:0]                pin_oe;
  logic [15:0]                analog_en;
  logic [31:0]                drive_level;
  logic [7:0]                 dl_cd;
  logic [7:0]                 dl_ef;
  pfds_pkg::pfds_periph_out_t periph_out = '0;
  pfds_pkg::pfds_periph_in_t  periph_in;
  pfds_pkg::pfds_periph_out_t p;
  logic [7:0]                 shadow [0:7];
  logic [31:0]                rd;
  logic                       err;
  logic [15:0]                v;
  int                         errors = 0;
  int                         checks = 0;
  int                         cycles = 0;

  always #12.5 clk = ~clk;

  pfds_top pfds_top_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_out(gpio_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .analog_en(analog_en),
    .drive_level(drive_level), .drive_level_ports_c_d(dl_cd), .drive_level_ports_e_f(dl_ef),
    .periph_out(periph_out), .periph_in(periph_in));
  pfds_pin_model pfds_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] exp_drive(input logic [7:0] ab);
    logic [31:0] r;
    for (int n = 0; n < 16; n++) r[2*n+:2] = ab[2*(n/4)+:2];
    return r;
  endfunction

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // every transfer starts just after a rising edge; pready is sampled at rising edges only
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, 8'(i * 4), {24'h0, d});
    `chk("write error", 1'b0, err);
    shadow[i] = d;
  endtask

  task automatic rd_chk(input int i);
    apb(1'b0, 8'(i * 4), 32'h0);
    `chk("read back", {24'h0, shadow[i] & (i == 3 ? pfds_pkg::FUNC_A_LOW_MASK : 8'hFF)}, rd);
  endtask

  // outputs are registered behind the register, so give them time to land
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(32'h022E));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) shadow[i] = (i >= 6) ? pfds_pkg::DIR_RESET : pfds_pkg::FIELD_RESET;
    settle();
    `chk("reset drive", 32'h0, drive_level);
    `chk("reset oe", 16'h0, pin_oe);
    `chk("idle inputs", 12'hFFF, periph_in);
    for (int i = 0; i < 8; i++) rd_chk(i);
    // status read, read-only status and an unmapped place
    @(posedge clk);
    ext_level <= 16'($urandom);
    settle();
    apb(1'b0, pfds_pkg::ADDR_STATUS, 32'h0);
    `chk("status", {16'h0, ext_level}, rd);
    apb(1'b1, pfds_pkg::ADDR_STATUS, 32'hFF);
    `chk("status write err", 1'b1, err);
    apb(1'b1, 8'h24, 32'hFF);
    `chk("unmapped write err", 1'b1, err);
    apb(1'b0, 8'h24, 32'h0);
    `chk("unmapped read", 33'h1_0000_0000, {err, rd});
    // every drive code, then random register traffic
    for (int c = 0; c < 4; c++) begin
      wr(0, {4{2'(c)}});
      settle();
      `chk("drive code", {16{2'(c)}}, drive_level);
    end
    for (int k = 0; k < 16; k++) begin
      int i;
      i = $urandom_range(0, 7);
      wr(i, 8'($urandom));
      rd_chk(i);
    end
    settle();
    `chk("drive ab", exp_drive(shadow[0]), drive_level);
    `chk("drive cd", shadow[1], dl_cd);
    `chk("drive ef", shadow[2], dl_ef);
    // gpio outputs
    for (int i = 3; i < 8; i++) wr(i, (i >= 6) ? 8'h00 : 8'h00);
    @(posedge clk);
    gpio_out <= 16'($urandom);
    settle();
    `chk("gpio oe", 16'hFFFF, pin_oe);
    `chk("gpio out", gpio_out, pin_out);
    // select pin functions before the peripherals start driving
    wr(3, 8'hCC);
    wr(4, 8'hFF);
    wr(5, 8'hAB);
    for (int k = 0; k < 2; k++) begin
      p = pfds_pkg::pfds_periph_out_t'($urandom);
      if (k == 1) p = ~periph_out;
      @(posedge clk);
      periph_out <= p;
      settle();
      `chk("periph pins", {p.serial_data_output, p.serial_slave_select, p.uart0_transmit, p.uart0_transmit,
        p.serial_clock, p.serial_data_input_line, p.timer2_pulse_output, p.timer3_pulse_output,
        p.uart2_transmit, p.comparator0_output},
        {pin_out[3], pin_out[1], pin_out[7:4], pin_out[11:8]});
      `chk("periph pin inputs", {p.serial_slave_select, p.uart0_transmit, p.serial_clock, p.serial_data_input_line},
        {periph_in.serial_slave_select_in, periph_in.uart0_receive, periph_in.serial_clock_in,
        periph_in.serial_data_in});
    end
    // quiet the peripherals before handing pins back
    @(posedge clk);
    periph_out <= '0;
    wr(3, 8'h88);
    wr(4, 8'h80);
    wr(5, 8'hFF);
    settle();
    `chk("code 10 gpio", {gpio_out[7], gpio_out[3]}, {pin_out[7], pin_out[3]});
    `chk("analog", 4'b1110, analog_en[11:8]);
    // peripheral inputs from pins set as inputs
    wr(3, 8'h00);
    wr(4, 8'h00);
    wr(5, 8'h00);
    wr(6, 8'hFF);
    wr(7, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      v = 16'($urandom);
      @(posedge clk);
      ext_level <= v;
      settle();
      `chk("periph inputs", {v[5], v[4], v[10], v[9], v[8]}, {periph_in.external_interrupt_input[3:2],
        periph_in.timer2_clock_input, periph_in.timer3_clock_input,
        periph_in.standard_timer2_clock_input});
    end
    // pin set as output, or given another function, leaves its input idle
    wr(6, 8'hDF);
    wr(5, 8'h08);
    @(posedge clk);
    ext_level <= 16'h0;
    gpio_out <= 16'h0;
    settle();
    `chk("idle input", 3'b101, {periph_in.external_interrupt_input[3:2],
      periph_in.timer3_clock_input});
    wrap_up();
  end
endmodule
